// ---- rtl/dmrf_pkg.sv ----
// Package for the data memory register file: address map and field layout.
// Assumes a 12-bit byte address space of sixteen 256-byte banks.
package dmrf_pkg;
  localparam int DMRF_AW = 12;
  localparam int DMRF_DW = 8;
  localparam int DMRF_OFS_W = 8;
  localparam int DMRF_BANK_W = 4;
  // General purpose RAM sits from address zero up to the special region
  localparam logic [11:0] DMRF_GPR_BASE = 12'h000;
  localparam logic [11:0] DMRF_SFR_BASE = 12'hdfa;
  localparam logic [11:0] DMRF_GPR_TOP = 12'hdf9;
  localparam int DMRF_GPR_DEPTH = 3578;
  localparam int DMRF_GPR_IW = 12;
  // Access window split: low part to bank 0, high part to bank 15
  localparam logic [7:0] DMRF_ACC_SPLIT = 8'h60;
  localparam logic [3:0] DMRF_ACC_LO_BANK = 4'h0;
  localparam logic [3:0] DMRF_ACC_HI_BANK = 4'hf;
  // Number of banks that exist; banks at or above read zero
  localparam logic [4:0] DMRF_NUM_BANKS = 5'h10;
  // Core registers, low byte of their bank 15 address
  localparam logic [7:0] DMRF_INTERRUPT_CONTROL_THREE = 8'hf0;
  localparam logic [7:0] DMRF_INTERRUPT_CONTROL_TWO = 8'hf1;
  localparam logic [7:0] DMRF_INTERRUPT_CONTROL_MAIN = 8'hf2;
  localparam logic [7:0] DMRF_MULTIPLY_PRODUCT_LOW = 8'hf3;
  localparam logic [7:0] DMRF_MULTIPLY_PRODUCT_HIGH = 8'hf4;
  localparam logic [7:0] DMRF_TABLE_LATCH = 8'hf5;
  localparam logic [7:0] DMRF_TABLE_POINTER_LOW = 8'hf6;
  localparam logic [7:0] DMRF_TABLE_POINTER_HIGH = 8'hf7;
  localparam logic [7:0] DMRF_TABLE_POINTER_UPPER = 8'hf8;
  localparam logic [7:0] DMRF_PROGRAM_COUNTER_LOW = 8'hf9;
  localparam logic [7:0] DMRF_PROGRAM_COUNTER_LATCH_HIGH = 8'hfa;
  localparam logic [7:0] DMRF_PROGRAM_COUNTER_LATCH_UPPER = 8'hfb;
  localparam logic [7:0] DMRF_RETURN_STACK_POINTER = 8'hfc;
  localparam logic [7:0] DMRF_STACK_TOP_LOW = 8'hfd;
  localparam logic [7:0] DMRF_STACK_TOP_HIGH = 8'hfe;
  localparam logic [7:0] DMRF_STACK_TOP_UPPER = 8'hff;
  localparam logic [11:0] DMRF_CORE_BASE = 12'hff0;
  localparam int DMRF_CORE_N = 16;
  localparam logic [11:0] DMRF_BANK_POINTER_ADDR = 12'hfe0;
  // Implemented bit masks; unimplemented bits read zero
  localparam logic [7:0] DMRF_MASK_FULL = 8'hff;
  localparam logic [7:0] DMRF_MASK_UPPER5 = 8'h1f;
  localparam logic [7:0] DMRF_MASK_TBLU = 8'h3f;
  localparam logic [7:0] DMRF_MASK_RETURN_STACK_POINTER = 8'hdf;
  localparam logic [7:0] DMRF_MASK_BANKPTR = 8'h0f;
  localparam logic [7:0] DMRF_ZERO = 8'h00;
endpackage

// ---- rtl/dmrf_gpr_mem.sv ----
// Uninitialised synchronous RAM for general purpose storage.
// Assumes one access per cycle; read data come out of a register.
`timescale 1ns/1ns
module dmrf_gpr_mem
  import dmrf_pkg::*;
(
  input wire logic clk,
  input wire logic we,
  input wire logic [DMRF_GPR_IW-1:0] addr,
  input wire logic [DMRF_DW-1:0] wdata,
  output logic [DMRF_DW-1:0] rdata
);
  logic [DMRF_DW-1:0] mem [0:DMRF_GPR_DEPTH-1];

  // No reset on the array: contents survive every reset
  always_ff @(posedge clk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
    rdata <= mem[addr];
  end
endmodule

// ---- rtl/dmrf_top.sv ----
// Data memory register file: general RAM below, core registers on top.
// Assumes the core presents one access per cycle on the data port and
// samples read data one clock after the request.
//
// Contract
// - General RAM from address zero upward contiguously
// - General RAM is plain storage, no side effects
// - General RAM not initialised at power-up
// - General RAM untouched by any later reset
// - Special registers from DFAh up to FFFh
// - Special registers are held storage cells
// - Unimplemented special addresses read as zero
// - Access offsets 60h-FFh map to bank 15
// - Unimplemented bank: writes ignored, reads zero
`timescale 1ns/1ns
module dmrf_top
  import dmrf_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic req,
  input wire logic we,
  input wire logic use_access,
  input wire logic use_full,
  input wire logic [DMRF_AW-1:0] full_addr,
  input wire logic [DMRF_OFS_W-1:0] offset,
  input wire logic [DMRF_DW-1:0] wdata,
  output logic [DMRF_DW-1:0] rdata,
  output logic rvalid,
  output logic [DMRF_BANK_W-1:0] bank_pointer
);
  logic [DMRF_AW-1:0] eff_addr;
  logic [DMRF_BANK_W-1:0] eff_bank;
  logic bank_ok;
  logic in_gpr;
  logic in_core;
  logic is_bptr;
  logic gpr_we;
  logic [DMRF_GPR_IW-1:0] gpr_addr;
  logic [DMRF_DW-1:0] gpr_rdata;
  logic [3:0] core_idx;
  logic [DMRF_DW-1:0] core_regs [0:DMRF_CORE_N-1];
  logic [DMRF_DW-1:0] next_core_regs [0:DMRF_CORE_N-1];
  logic [DMRF_BANK_W-1:0] next_bank_pointer;
  logic [DMRF_DW-1:0] sfr_rdata;
  logic [DMRF_DW-1:0] next_sfr_rdata;
  logic sel_gpr;
  logic next_sel_gpr;
  logic next_rvalid;

  function automatic logic [7:0] core_mask(input logic [3:0] i);
    logic [7:0] m;
    m = DMRF_MASK_FULL;
    case ({4'hf, i})
      DMRF_TABLE_POINTER_UPPER: m = DMRF_MASK_TBLU;
      DMRF_PROGRAM_COUNTER_LATCH_UPPER: m = DMRF_MASK_UPPER5;
      DMRF_RETURN_STACK_POINTER: m = DMRF_MASK_RETURN_STACK_POINTER;
      DMRF_STACK_TOP_UPPER: m = DMRF_MASK_UPPER5;
      default: m = DMRF_MASK_FULL;
    endcase
    return m;
  endfunction

  // Address generation: full, access window or banked
  always_comb begin
    if (use_full) begin
      eff_addr = full_addr;
    end else if (use_access) begin
      if (offset >= DMRF_ACC_SPLIT) begin
        eff_addr = {DMRF_ACC_HI_BANK, offset};
      end else begin
        eff_addr = {DMRF_ACC_LO_BANK, offset};
      end
    end else begin
      eff_addr = {bank_pointer, offset};
    end
  end

  assign eff_bank = eff_addr[DMRF_AW-1 -: DMRF_BANK_W];
  // All banks exist here; the check keeps smaller variants honest
  assign bank_ok = {1'b0, eff_bank} < DMRF_NUM_BANKS;
  assign in_gpr = bank_ok && (eff_addr <= DMRF_GPR_TOP);
  assign in_core = bank_ok && (eff_addr >= DMRF_CORE_BASE);
  assign is_bptr = bank_ok && (eff_addr == DMRF_BANK_POINTER_ADDR);
  assign core_idx = eff_addr[3:0];
  assign gpr_we = req && we && in_gpr;
  assign gpr_addr = eff_addr - DMRF_GPR_BASE;

  dmrf_gpr_mem u_gpr (
    .clk(clk),
    .we(gpr_we),
    .addr(gpr_addr),
    .wdata(wdata),
    .rdata(gpr_rdata)
  );

  // Special register next state; behaviour behind each is elsewhere
  always_comb begin
    for (int i = 0; i < DMRF_CORE_N; i++) begin
      next_core_regs[i] = core_regs[i];
    end
    next_bank_pointer = bank_pointer;
    if (req && we && in_core) begin
      next_core_regs[core_idx] = wdata & core_mask(core_idx);
    end
    if (req && we && is_bptr) begin
      next_bank_pointer = wdata[DMRF_BANK_W-1:0];
    end
  end

  // Read path; everything in the special region not backed reads zero
  always_comb begin
    next_sfr_rdata = DMRF_ZERO;
    next_sel_gpr = 1'b0;
    next_rvalid = req && !we;
    if (req && !we) begin
      if (in_gpr) begin
        next_sel_gpr = 1'b1;
      end else if (in_core) begin
        next_sfr_rdata = core_regs[core_idx];
      end else if (is_bptr) begin
        next_sfr_rdata = {4'h0, bank_pointer} & DMRF_MASK_BANKPTR;
      end else begin
        next_sfr_rdata = DMRF_ZERO;
      end
    end
  end

  // Special registers hold a defined value after reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < DMRF_CORE_N; i++) begin
        core_regs[i] <= DMRF_ZERO;
      end
      bank_pointer <= '0;
      sfr_rdata <= DMRF_ZERO;
      sel_gpr <= 1'b0;
      rvalid <= 1'b0;
    end else begin
      for (int i = 0; i < DMRF_CORE_N; i++) begin
        core_regs[i] <= next_core_regs[i];
      end
      bank_pointer <= next_bank_pointer;
      sfr_rdata <= next_sfr_rdata;
      sel_gpr <= next_sel_gpr;
      rvalid <= next_rvalid;
    end
  end

  // RAM is outside reset so it is neither cleared nor disturbed
  assign rdata = sel_gpr ? gpr_rdata : sfr_rdata;
endmodule

// ---- sim/dmrf_monitor.sv ----
// Port checker for the data memory register file.
// Assumes one clock and an async active-low reset.
`timescale 1ns/1ns
module dmrf_monitor (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic req,
  input wire logic we,
  input wire logic use_access,
  input wire logic use_full,
  input wire logic [11:0] full_addr,
  input wire logic [7:0] offset,
  input wire logic [7:0] wdata,
  input wire logic [7:0] rdata,
  input wire logic rvalid,
  input wire logic [3:0] bank_pointer
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire rd = req && !we;
  wire fr = rd && use_full;
  wire bp = use_full && full_addr == 12'hfe0;
  chk_read_ack: assert property (rd |=> rvalid) else $error("rvalid");
  chk_no_ack: assert property (!rd |=> !rvalid) else $error("rvalid");
  chk_bank_write: assert property (req && we && bp |=>
    {4'h0, bank_pointer} == ($past(wdata) & 8'h0f)) else $error("bank");
  chk_bank_hold: assert property (!(req && we) |=>
    $stable(bank_pointer)) else $error("bank hold");
  chk_bank_read: assert property (rd && bp |=>
    rdata == {4'h0, bank_pointer}) else $error("bank read");
  chk_unimpl_zero: assert property (fr && full_addr[11:8] == 4'he |=>
    rdata == 8'h00) else $error("unimpl");
  chk_acc_high: assert property (rd && use_access && !use_full &&
    offset == 8'he0 |=> rdata == {4'h0, bank_pointer}) else $error("acc");
  chk_top_mask: assert property (fr && full_addr == 12'hfff |=>
    rdata[7:5] == 3'h0) else $error("mask");
endmodule
bind dmrf_top dmrf_monitor dmrf_monitor_i (.*);

// ---- sim/dmrf_core_model.sv ----
// Core-side model issuing one data access per cycle.
// Assumes each call starts just after a rising clk edge.
`timescale 1ns/1ns
module dmrf_core_model (
  input wire logic clk,
  input wire logic [7:0] rdata,
  input wire logic rvalid,
  output logic req,
  output logic we,
  output logic use_access,
  output logic use_full,
  output logic [11:0] full_addr,
  output logic [7:0] offset,
  output logic [7:0] wdata
);
  initial {req, we, use_access, use_full, full_addr, offset, wdata} = '0;
  task automatic acc(input logic w, ua, uf, input logic [11:0] a,
      input logic [7:0] o, d, output logic [7:0] q, output logic v);
    {req, we, use_access, use_full} = {1'b1, w, ua, uf};
    {full_addr, offset, wdata} = {a, o, d};
    @(posedge clk);
    #1;
    q = rdata;
    v = rvalid;
  endtask
  // Inverted so stale lines never look valid
  task automatic idle();
    {req, full_addr, wdata} = {1'b0, ~full_addr, ~wdata};
    @(posedge clk);
    #1;
  endtask
endmodule

// ---- sim/testbench.sv ----
// Self-checking bench for the data memory register file.
// Assumes the core model drives the data port.
`timescale 1ns/1ns
module testbench;
  import dmrf_pkg::*;
  logic clk = 0, rst_n = 0, req, we, use_access, use_full, rvalid, v;
  logic [11:0] full_addr, a;
  logic [7:0] offset, wdata, rdata, q, d, o;
  logic [3:0] bank_pointer, b;
  logic [7:0] mem [logic [11:0]];
  int miscompares = 0, checks_done = 0;
  always #5 clk = ~clk;
  dmrf_top dmrf_top_i (.clk, .rst_n, .req, .we, .use_access, .use_full,
    .full_addr, .offset, .wdata, .rdata, .rvalid, .bank_pointer);
  dmrf_core_model dmrf_core_model_i (.clk, .rdata, .rvalid, .req, .we,
    .use_access, .use_full, .full_addr, .offset, .wdata);
  task check(input logic [7:0] got, exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  function automatic logic [7:0] mask(input int r);
    case (r)
      8: return 8'h3f;
      11, 15: return 8'h1f;
      12: return 8'hdf;
      default: return 8'hff;
    endcase
  endfunction
  task wr(input logic ua, uf, input logic [11:0] x, input logic [7:0] y, z);
    dmrf_core_model_i.acc(1'b1, ua, uf, x, y, z, q, v);
  endtask
  task rd(input logic ua, uf, input logic [11:0] x, input logic [7:0] y, e);
    dmrf_core_model_i.acc(1'b0, ua, uf, x, y, 8'h00, q, v);
    check({7'h0, v}, 8'h01);
    check(q, e);
  endtask
  task stop_test();
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    #300000;
    miscompares++;
    stop_test();
  end
  initial begin
    void'($urandom(2));
    repeat (10) @(posedge clk);
    #1 rst_n = 1;
    for (int i = 0; i < 24; i++) begin
      d = 8'($urandom);
      o = 8'($urandom);
      case (i % 3)
        0: begin
          a = (i == 0) ? DMRF_GPR_TOP : 12'($urandom % 3578);
          wr(0, 1, a, 0, d);
        end
        1: begin
          a = 12'($urandom % 96);
          wr(1, 0, 0, a[7:0], d);
        end
        default: begin
          b = 4'($urandom % 13);
          wr(0, 1, 12'hfe0, 0, {4'h0, b});
          a = {b, o};
          wr(0, 0, 0, o, d);
        end
      endcase
      mem[a] = d;
    end
    foreach (mem[k]) rd(0, 1, k, 0, mem[k]);
    $display("gpr test done");
    for (int r = 0; r < 16; r++) begin
      d = 8'($urandom);
      wr(0, 1, DMRF_CORE_BASE + 12'(r), 0, d);
      rd(0, 1, DMRF_CORE_BASE + 12'(r), 0, d & mask(r));
      rd(1, 0, 0, 8'hf0 + 8'(r), d & mask(r));
    end
    wr(0, 1, 12'hfe0, 0, 8'hff);
    check({4'h0, bank_pointer}, 8'h0f);
    rd(0, 1, 12'hfe0, 0, 8'h0f);
    rd(1, 0, 0, 8'he0, 8'h0f);
    a = 12'he00 + 12'($urandom % 224);
    wr(0, 1, a, 0, 8'ha5);
    rd(0, 1, a, 0, 8'h00);
    wr(0, 1, DMRF_SFR_BASE, 0, 8'h5a);
    rd(0, 1, DMRF_SFR_BASE, 0, 8'h00);
    $display("sfr test done");
    dmrf_core_model_i.idle();
    rst_n = 0;
    #20 rst_n = 1;
    foreach (mem[k]) rd(0, 1, k, 0, mem[k]);
    rd(1, 0, 0, 8'he0, 8'h00);
    $display("reset test done");
    stop_test();
  end
endmodule
